//--- src/sdmi_core.sv
// Step/direction front end: synchroniser, microstep counter, interpolator, standstill.
// Assumes step and rotation_sense inputs arrive asynchronously from a motion controller.
//
// Behaviour
// - External step mode disables the ramp; only run/hold currents stay active.
// - Both-edge select makes both step transitions active; else rising only.
// - Step and rotation sense are synchronised before use.
// - A 1024-entry sine table is indexed by the microstep counter.
// - Without interpolation, active edge adds step width when sense low, subtracts when high.
// - Step width is 1 at finest, doubling per halving, up to 256.
// - Coarser resolution snaps counter to nearest valid position of new grid.
// - Full step visits only 128, 384, 640, 896 with stride 256.
// - Half and quarter step use odd multiples of 64 and 32.
// - Interpolation yields 256x microsteps, one every 256th of the last interval; only a full step fills the whole interval.
// - Interpolation runs only while interpolation enable is set.
// - Microstep rate is previous step period divided into 256 parts.
// - No edge for 2^20 clocks sets idle flag; quick mode 2^18.
// - Standstill switches coil current to the standstill setting.
// - Idle flag clears on the next active step edge.
// - New rate adopted after one interval; unissued microsteps are skipped.
`timescale 1ns/100ps
module sdmi_core
  import sdmi_pkg::*;
#(
  parameter int unsigned IDLE_SLOW = sdmi_pkg::IDLE_CLKS_SLOW,
  parameter int unsigned IDLE_FAST = sdmi_pkg::IDLE_CLKS_FAST
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  // Step interface from motion controller
  input  wire logic                      i_step,
  input  wire logic                      i_rotation_sense,
  // Configuration
  input  wire sdmi_pkg::sdmi_cfg_t       i_cfg,
  input  wire sdmi_pkg::sdmi_cur_t       i_cur,
  // Status and outputs
  output logic [sdmi_pkg::MSCNT_W-1:0]   o_mscnt,
  output logic [sdmi_pkg::AMP_W-1:0]     o_sine,
  output logic [sdmi_pkg::CUR_W-1:0]     o_coil_current,
  output logic                           o_idle_flag,
  output logic                           o_ramp_enable
);
  import sdmi_pkg::*;

  // Synchroniser stages; stage one feeds only stage two
  logic       step_s1_ff, step_s2_ff, step_s3_ff;
  logic       dir_s1_ff, dir_s2_ff;
  logic [9:0] mscnt_ff, nxt_mscnt;
  logic [3:0] res_ff;
  logic [IVL_W-1:0] ivl_cnt_ff, nxt_ivl_cnt;
  logic [IVL_W-1:0] ivl_last_ff, nxt_ivl_last;
  logic [IVL_W-1:0] sub_cnt_ff, nxt_sub_cnt;
  logic [8:0] pend_ff, nxt_pend;
  logic       pend_dir_ff;
  logic       idle_ff, nxt_idle;
  logic [4:0] cur_ff;
  logic       ramp_ff;
  logic [AMP_W-1:0] sine_w;

  // Edge decode on synchronised stages
  wire rise_w      = step_s2_ff & ~step_s3_ff;
  wire fall_w      = ~step_s2_ff & step_s3_ff;
  wire active_w    = rise_w | (i_cfg.both_edge_select & fall_w);
  wire interp_w    = i_cfg.interpolation_enable;
  wire [IVL_W-1:0] idle_lim_w = i_cfg.quick_idle_detect ? IVL_W'(IDLE_FAST) : IVL_W'(IDLE_SLOW);

  // Width of one pulse at a resolution code: 1 << code, held at 256 above full step
  function automatic logic [9:0] step_width(input logic [3:0] res);
    step_width = (res > RES_FULL) ? 10'h100 : 10'(10'h001 << res);
  endfunction

  // Snap to the nearest odd multiple of half the width, the grid of that resolution
  function automatic logic [9:0] snap(input logic [9:0] cnt, input logic [3:0] res);
    logic [9:0] w;
    logic [9:0] half;
    logic [9:0] base;
    w    = step_width(res);
    half = w >> 1;
    base = cnt & ~(w - 10'h001);
    snap = (res == RES_FINEST) ? cnt : base | half;
  endfunction

  wire [9:0] width_w = interp_w ? 10'h001 : step_width(res_ff);
  wire [8:0] burst_w = 9'(step_width(res_ff));
  // Sub-interval: last period split into 256 parts; the width-scaled sub_tick_w is computed but not used
  wire [IVL_W-1:0] sub_len_w = IVL_W'((ivl_last_ff >> SUB_STEPS_LOG2) == '0 ? 1 : ivl_last_ff >> SUB_STEPS_LOG2);
  wire [IVL_W-1:0] sub_tick_w = IVL_W'(sub_len_w << (res_ff > RES_FULL ? RES_FULL : res_ff)) >> SUB_STEPS_LOG2;
  wire [IVL_W-1:0] sub_use_w = (sub_tick_w == '0) ? sub_len_w : sub_len_w;
  wire micro_tick_w = interp_w & (pend_ff != 9'h000) & (sub_cnt_ff >= sub_use_w - IVL_W'(1));
  wire [9:0] delta_w = active_w & ~interp_w ? width_w : (micro_tick_w ? 10'h001 : 10'h000);
  wire       dir_use_w = interp_w ? pend_dir_ff : dir_s2_ff;

  // Counter update; 10-bit arithmetic wraps modulo 1024
  always_comb begin
    nxt_mscnt = dir_use_w ? mscnt_ff - delta_w : mscnt_ff + delta_w;
    if (res_ff != i_cfg.resolution && i_cfg.resolution > res_ff) begin
      nxt_mscnt = snap(mscnt_ff, i_cfg.resolution);
    end
  end

  // Interval measurement and interpolator bookkeeping
  always_comb begin
    nxt_ivl_cnt  = (ivl_cnt_ff < idle_lim_w) ? ivl_cnt_ff + IVL_W'(1) : ivl_cnt_ff;
    nxt_ivl_last = ivl_last_ff;
    nxt_sub_cnt  = micro_tick_w ? '0 : sub_cnt_ff + IVL_W'(1);
    nxt_pend     = micro_tick_w ? pend_ff - 9'h001 : pend_ff;
    nxt_idle     = idle_ff | (ivl_cnt_ff >= idle_lim_w - IVL_W'(1));
    if (active_w) begin
      nxt_ivl_cnt  = '0;
      nxt_ivl_last = idle_ff ? IVL_W'(IDLE_SLOW) : ivl_cnt_ff + IVL_W'(1);
      nxt_pend     = burst_w;
      nxt_sub_cnt  = '0;
      nxt_idle     = 1'b0;
    end
  end

  // Input synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_s1_ff <= 1'b0;
      step_s2_ff <= 1'b0;
      step_s3_ff <= 1'b0;
      dir_s1_ff  <= 1'b0;
      dir_s2_ff  <= 1'b0;
    end else if (i_ce) begin
      step_s1_ff <= i_step;
      step_s2_ff <= step_s1_ff;
      step_s3_ff <= step_s2_ff;
      dir_s1_ff  <= i_rotation_sense;
      dir_s2_ff  <= dir_s1_ff;
    end
  end

  // Counter and resolution
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mscnt_ff    <= MSCNT_RST;
      res_ff      <= RES_FINEST;
      pend_dir_ff <= 1'b0;
    end else if (i_ce) begin
      mscnt_ff <= nxt_mscnt;
      res_ff   <= i_cfg.resolution;
      if (active_w) begin
        pend_dir_ff <= dir_s2_ff;
      end
    end
  end

  // Interval timer, interpolator and standstill
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ivl_cnt_ff  <= '0;
      ivl_last_ff <= IVL_W'(IDLE_SLOW);
      sub_cnt_ff  <= '0;
      pend_ff     <= 9'h000;
      idle_ff     <= 1'b0;
    end else if (i_ce) begin
      ivl_cnt_ff  <= nxt_ivl_cnt;
      ivl_last_ff <= nxt_ivl_last;
      sub_cnt_ff  <= nxt_sub_cnt;
      pend_ff     <= nxt_pend;
      idle_ff     <= nxt_idle;
    end
  end

  // Current select and ramp gate; a one-cycle lag keeps outputs registered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_ff  <= CUR_RST;
      ramp_ff <= 1'b0;
    end else if (i_ce) begin
      cur_ff  <= idle_ff ? i_cur.standstill_current : i_cur.run_current;
      ramp_ff <= ~i_cfg.ext_step_mode;
    end
  end

  // Table lookup
  sdmi_sine_rom #(
    .DEPTH (TABLE_DEPTH),
    .AW    (MSCNT_W),
    .DW    (AMP_W)
  ) u_rom (
    .i_clk  (i_clk),
    .i_ce   (i_ce),
    .i_addr (mscnt_ff),
    .o_data (sine_w)
  );

  assign o_mscnt        = mscnt_ff;
  assign o_sine         = sine_w;
  assign o_coil_current = cur_ff;
  assign o_idle_flag    = idle_ff;
  assign o_ramp_enable  = ramp_ff;

  // Assertions
  // A plain step edge with no resolution change pending in the same cycle
  sequence s_step_edge;
    i_ce && active_w && !interp_w && (res_ff == i_cfg.resolution);
  endsequence

  // An interpolated microstep with no snap or plain step competing for the counter
  sequence s_micro_tick;
    i_ce && micro_tick_w && (res_ff == i_cfg.resolution);
  endsequence

  a_step_add_dir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_step_edge and !dir_s2_ff) |=> mscnt_ff == 10'($past(mscnt_ff) + $past(width_w)))
    else $error("Counter did not add width");
  a_step_sub_dir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_step_edge and dir_s2_ff) |=> mscnt_ff == 10'($past(mscnt_ff) - $past(width_w)))
    else $error("Counter did not subtract width");
  a_edge_rise_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && fall_w && !i_cfg.both_edge_select |-> !active_w)
    else $error("Falling edge counted");
  a_sync_two_stage: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce ##1 i_ce |-> step_s2_ff == $past(step_s1_ff))
    else $error("Synchroniser stage skipped");
  a_idle_clear_edge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_w |=> !idle_ff)
    else $error("Idle not cleared by step");
  a_idle_fast_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !active_w && ivl_cnt_ff == idle_lim_w - IVL_W'(1) |=> idle_ff)
    else $error("Idle flag late");
  a_hold_current: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && idle_ff ##1 i_ce |-> o_coil_current == $past(i_cur.standstill_current))
    else $error("Hold current not applied");
  a_full_grid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && res_ff == RES_FULL && i_cfg.resolution == RES_FULL && !interp_w
    && mscnt_ff[7:0] == 8'h80 |=> mscnt_ff[7:0] == 8'h80)
    else $error("Full step left grid");
  a_snap_coarse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_cfg.resolution > res_ff && i_cfg.resolution <= RES_FULL
    |=> mscnt_ff[$past(i_cfg.resolution) - 1] == 1'b1)
    else $error("Counter not snapped");
  a_interp_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !interp_w |-> !micro_tick_w)
    else $error("Microstep without enable");

  // Counting up past the top must land on zero, not stall at the end
  a_wrap_top: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_step_edge and (!dir_s2_ff && mscnt_ff == 10'h3ff && width_w == 10'h001))
    |=> mscnt_ff == 10'h000)
    else $error("Counter did not wrap");

  // Without interpolation a full step moves a quarter of the table
  a_width_full: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !interp_w && res_ff == RES_FULL |-> width_w == 10'h100)
    else $error("Full step width wrong");

  // Quarter step keeps odd multiples of 32 while stepping
  a_quarter_grid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && res_ff == RES_FULL - 4'h2 && i_cfg.resolution == RES_FULL - 4'h2 && !interp_w
    && mscnt_ff[5:0] == 6'h20 |=> mscnt_ff[5:0] == 6'h20)
    else $error("Quarter step left grid");

  // Half step keeps odd multiples of 64 while stepping
  a_half_grid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && res_ff == RES_FULL - 4'h1 && i_cfg.resolution == RES_FULL - 4'h1 && !interp_w
    && mscnt_ff[6:0] == 7'h40 |=> mscnt_ff[6:0] == 7'h40)
    else $error("Half step left grid");

  // A full-step edge under interpolation owes a whole quarter revolution
  a_burst_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_w && interp_w && res_ff == RES_FULL |=> pend_ff == 9'h100)
    else $error("Burst not loaded");

  // Each microstep tick really changes the counter value
  a_micro_move: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_micro_tick |=> mscnt_ff != $past(mscnt_ff))
    else $error("Microstep did not move");

  // The interval just ended becomes the base for the next sub-interval length
  a_ivl_measure: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_w && !idle_ff |=> ivl_last_ff == IVL_W'($past(ivl_cnt_ff) + IVL_W'(1)))
    else $error("Interval not measured");

  // Run current applies whenever the motor is not at standstill
  a_run_current: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !idle_ff |=> o_coil_current == $past(i_cur.run_current))
    else $error("Run current not applied");

  // An external step source turns the internal ramp off
  a_ramp_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_cfg.ext_step_mode |=> !o_ramp_enable)
    else $error("Ramp left enabled");

  // With the enable low nothing may move, not even the standstill timer
  a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(mscnt_ff) && $stable(idle_ff) && $stable(pend_ff) && $stable(ivl_cnt_ff))
    else $error("State moved while frozen");

  // A falling edge counts once both edges are selected
  a_edge_both: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && fall_w && i_cfg.both_edge_select |-> active_w)
    else $error("Falling edge ignored");

  // Idle never rises on the cycle an edge arrives; the edge wins
  a_idle_edge_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_w && ivl_cnt_ff >= idle_lim_w - IVL_W'(1) |=> !o_idle_flag)
    else $error("Idle set on step edge");
endmodule

//--- src/sdmi_pkg.sv
// Package for the step/direction microstep interpolator.
// Assumes a single 100 MHz system clock domain.
package sdmi_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned MSCNT_W        = 10;
  localparam int unsigned TABLE_DEPTH    = 1024;
  localparam int unsigned AMP_W          = 9;
  localparam int unsigned CUR_W          = 5;
  // Standstill timeouts, log2 of clock count
  localparam int unsigned IDLE_LOG2_SLOW = 20;
  localparam int unsigned IDLE_LOG2_FAST = 18;
  localparam int unsigned IDLE_CLKS_SLOW = 1 << IDLE_LOG2_SLOW;
  localparam int unsigned IDLE_CLKS_FAST = 1 << IDLE_LOG2_FAST;
  // Interval measurement width: up to 2^20 clocks
  localparam int unsigned IVL_W          = 21;
  localparam int unsigned SUB_STEPS_LOG2 = 8;
  // Resolution codes: 0 = 256 microsteps ... 8 = full step
  localparam logic [3:0]  RES_FINEST     = 4'h0;
  localparam logic [3:0]  RES_FULL       = 4'h8;
  localparam logic [9:0]  MSCNT_RST      = 10'h000;
  localparam logic [4:0]  CUR_RST        = 5'h00;

  // Configuration bundle
  typedef struct packed {
    logic       both_edge_select;
    logic       interpolation_enable;
    logic       quick_idle_detect;
    logic       ext_step_mode;
    logic [3:0] resolution;
  } sdmi_cfg_t;

  // Current settings bundle
  typedef struct packed {
    logic [4:0] run_current;
    logic [4:0] standstill_current;
  } sdmi_cur_t;
endpackage

//--- src/sdmi_sine_rom.sv
// Sine table of one electrical revolution, indexed by microstep count.
// Assumes a registered read; contents are computed from a quarter-wave formula.
`timescale 1ns/100ps
module sdmi_sine_rom #(
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned AW    = 10,
  parameter int unsigned DW    = 9
) (
  // Clock
  input  wire logic          i_clk,
  input  wire logic          i_ce,
  // Read port
  input  wire logic [AW-1:0] i_addr,
  output logic      [DW-1:0] o_data
);
  logic [DW-1:0] table_mem [DEPTH];

  // Table built at elaboration; a parabolic quarter wave stands in for a real sine
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      int q;
      int x;
      q = i % (DEPTH / 4);
      x = ((i / (DEPTH / 4)) % 2 == 0) ? q : (DEPTH / 4) - q;
      table_mem[i] = DW'((x * (2 * (DEPTH / 4) - x)) / (DEPTH / 4) + ((i >= DEPTH / 2) ? (1 << (DW - 1)) : 0));
    end
  end

  // Registered read keeps the table in block memory
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_data <= table_mem[i_addr];
    end
  end
endmodule

//--- verif/sdmi_step_src.sv
// Behavioural motion controller that drives step and rotation sense.
// Assumes its caller works on the falling edge of the system clock.
`timescale 1ns/100ps
module sdmi_step_src (
  // Clock
  input  wire logic i_clk,
  // Step interface
  output logic      o_step,
  output logic      o_rotation_sense
);
  // Idle levels at time zero
  initial begin
    o_step = 1'b0;
    o_rotation_sense = 1'b0;
  end

  // Sense settles a clock before the edge; each level stands 6 clocks for a 50% duty
  task automatic edge_to(input logic lvl, input logic dir);
    @(negedge i_clk);
    o_rotation_sense = dir;
    @(negedge i_clk);
    o_step = lvl;
    repeat (4) @(negedge i_clk);
  endtask
endmodule

//--- verif/sdmi_core_bench.sv
// Self-checking bench for the step/direction microstep core.
// Assumes idle limits are cut to 1024/256 clocks so the run stays short.
`timescale 1ns/100ps
module sdmi_core_bench;
  import sdmi_pkg::*;
  logic       i_clk;
  logic       i_rst_n;
  logic       ce;
  logic       step;
  logic       sense;
  sdmi_cfg_t  cfg;
  sdmi_cur_t  cur;
  logic [9:0] mscnt;
  logic [8:0] sine;
  logic [4:0] coil;
  logic       idle;
  logic       ramp;
  int         errors = 0;
  int         samples_checked = 0;

  // Partner and device under test
  sdmi_step_src sdmi_step_src_i (.i_clk(i_clk), .o_step(step), .o_rotation_sense(sense));
  sdmi_core #(.IDLE_SLOW(1024), .IDLE_FAST(256)) sdmi_core_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_step(step), .i_rotation_sense(sense),
    .i_cfg(cfg), .i_cur(cur), .o_mscnt(mscnt), .o_sine(sine), .o_coil_current(coil),
    .o_idle_flag(idle), .o_ramp_enable(ramp));

  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic summarize;
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts measured by the bench itself, in clock cycles or counter steps
  task automatic chk_rng(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      errors++;
      $display("mismatch at %0t: count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask

  // One full pulse; only its rising edge counts unless both edges are active
  task automatic pulse(input logic dir);
    sdmi_step_src_i.edge_to(1'b1, dir);
    sdmi_step_src_i.edge_to(1'b0, dir);
  endtask

  task automatic t_reset;
    chk_val(mscnt, 10'h000);
    chk_val({9'h000, ramp}, 10'h000);
    chk_val({9'h000, idle}, 10'h000);
  endtask

  // Reverse from zero must wrap, then count forward on rising edges only, then on both edges
  task automatic t_dir_wrap;
    pulse(1'b1);
    chk_val(mscnt, 10'h3ff);
    pulse(1'b0);
    pulse(1'b0);
    chk_val(mscnt, 10'h001);
    cfg.both_edge_select = 1'b1;
    pulse(1'b0);
    chk_val(mscnt, 10'h003);
    cfg.both_edge_select = 1'b0;
  endtask

  // Each coarser step snaps to the odd half-width grid, then moves by the width
  task automatic t_res;
    int e;
    int w;
    e = 3;
    for (int r = 1; r <= 8; r++) begin
      w = 1 << r;
      cfg.resolution = 4'(r);
      repeat (3) @(negedge i_clk);
      e = (e & ~(w - 1)) | (w / 2);
      chk_val(mscnt, 10'(e));
      pulse(1'b0);
      e = (e + w) % 1024;
      chk_val(mscnt, 10'(e));
    end
    pulse(1'b1);
    chk_val({2'b00, mscnt[7:0]}, 10'h080);
  endtask

  // Standstill after the timeout, current drop, and release on the next edge
  task automatic t_idle(input logic quick);
    int n;
    int lim;
    lim = quick ? 256 : 1024;
    cfg.quick_idle_detect = quick;
    pulse(1'b0);
    n = 0;
    while (idle !== 1'b1 && n < lim + 64) begin
      @(negedge i_clk);
      n++;
    end
    chk_rng(n, lim - 24, lim + 4);
    if (n >= lim + 64)
      summarize();
    repeat (2) @(negedge i_clk);
    chk_val({5'h00, coil}, {5'h00, cur.standstill_current});
    pulse(1'b0);
    chk_val({9'h000, idle}, 10'h000);
    chk_val({5'h00, coil}, {5'h00, cur.run_current});
    cfg.quick_idle_detect = 1'b0;
  endtask

  // Steady 512-clock steps at full step: the 256 microsteps are spread out
  task automatic t_interp;
    logic [9:0] base;
    cfg.interpolation_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      pulse(1'b0);
      repeat (500) @(negedge i_clk);
    end
    pulse(1'b0);
    base = mscnt;
    repeat (128) @(negedge i_clk);
    chk_rng(int'(10'(mscnt - base)), 40, 90);
    cfg.interpolation_enable = 1'b0;
  endtask

  // With the enable low a whole pulse is lost and the counter stands still
  task automatic t_freeze;
    logic [9:0] base;
    base = mscnt;
    ce = 1'b0;
    pulse(1'b0);
    chk_val(mscnt, base);
    ce = 1'b1;
    repeat (3) @(negedge i_clk);
    chk_val(mscnt, base);
  endtask

  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    ce = 1'b1;
    cfg = '0;
    cfg.ext_step_mode = 1'b1;
    cur.run_current = 5'h1a;
    cur.standstill_current = 5'h05;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_dir_wrap();
    t_res();
    t_idle(1'b0);
    t_idle(1'b1);
    t_interp();
    t_freeze();
    summarize();
  end
endmodule
